/* File: lc_pkg.sv */
package lc_pkg;
	// Cluster structure.
	localparam int	LC_ELEMS	= 8;
	localparam int	LC_NCLK		= 3;
	localparam int	LC_NSRC		= 2;
	localparam int	LC_WORDS	= 64;

	// Byte addresses of the cluster-wide words; element words sit at 9'h000 to 9'h0fc.
	localparam logic [8:0]	LC_OFF_CLK	= 9'h100;
	localparam logic [8:0]	LC_OFF_USE	= 9'h104;
	localparam logic [8:0]	LC_OFF_STAT	= 9'h108;

	// Values after reset.
	localparam logic [31:0]	LC_RST_WORD	= 32'h0000_0000;
	localparam logic	LC_RST_WAIT	= 1'b1;

	// Word slots inside each element's group of eight.
	localparam int	LC_W_T0		= 0;
	localparam int	LC_W_T1		= 2;
	localparam int	LC_W_SEL	= 4;
	localparam int	LC_W_MODE	= 6;
	localparam int	LC_W_STRIDE	= 8;

	// Element mode word fields.
	localparam int	LC_M_CLK	= 0;
	localparam int	LC_M_ACLR	= 2;
	localparam int	LC_M_SCLR	= 3;
	localparam int	LC_M_SLOAD	= 4;
	localparam int	LC_M_ALOAD	= 5;
	localparam int	LC_M_PACKF	= 6;
	localparam int	LC_M_MODE	= 7;
	localparam int	LC_M_D0		= 9;
	localparam int	LC_M_FB		= 13;
	localparam int	LC_M_OSEL	= 14;

	// Clock word fields: two source selects, then pick and falling bit per clock.
	localparam int	LC_C_SRC0	= 0;
	localparam int	LC_C_PICK	= 6;

	// Control use word fields.
	localparam int	LC_U_CLK	= 0;
	localparam int	LC_U_ENA	= 3;
	localparam int	LC_U_ACLR	= 6;
	localparam int	LC_U_SCLR	= 8;
	localparam int	LC_U_ALOAD	= 9;
	localparam int	LC_U_SLOAD	= 10;
	localparam int	LC_U_AIDX	= 11;
	localparam int	LC_U_AROW	= 14;
	localparam logic [3:0]	LC_MAX_CTL	= 4'hb;

	// Local control line positions.
	localparam int	LC_CI_CLK	= 0;
	localparam int	LC_CI_ENA	= 1;
	localparam int	LC_CI_ACLR	= 4;
	localparam int	LC_CI_SCLR	= 6;
	localparam int	LC_CI_ALOAD	= 7;
	localparam int	LC_CI_SLOAD	= 8;

	typedef enum logic [1:0] {
		LC_NORMAL = 2'h0, LC_EXTLUT = 2'h1, LC_ARITH = 2'h3, LC_SHARED = 2'h2
	} lc_mode_e;

	typedef enum logic [1:0] {
		LC_D_COMB = 2'h0, LC_D_PACK = 2'h1, LC_D_CHAIN = 2'h2, LC_D_CHAIN2 = 2'h3
	} lc_dsrc_e;
endpackage : lc_pkg

/* File: lc_cluster.sv */
`timescale 1ns/100ps
// Functional notes
// - The cluster holds eight elements sharing routing, chains and control lines.
// - Control set: three clocks, three enables, three clears, two loads; eleven at most.
// - Three cluster clocks draw on no more than two distinct sources.
// - Each cluster clock is gated by its own paired enable, except clock zero while the asynchronous load is used.
// - Rising and falling use of one source takes two cluster clocks.
// - An inactive enable stops its cluster clock for all users.
// - Asynchronous load with data one acts as a preset.
// - Using the asynchronous load removes clock enable zero.
// - Control lines come from row clocks five to zero and local routing.
// - Register chain feeds each register from the adjacent one.
// - Registers take data, clock, enable, clears and both loads.
// - Clocks and asynchronous clears may use row lines; the rest only local lines.
// - Asynchronous load data comes from input e or f.
// - Combinational results bypass the register to the outputs.
// - Each element has two registers, two adders and three chains.
// - Six-input function, two shared-input functions, or seven-input mux.
// - Two output sets of two outputs, one per set reaching local routing.
// - Look-up result and register may drive different outputs independently.
// - Register output may feed back into its own look-up table.
// - Registered and unregistered results may be shown at once.
// - Outputs reach local routing and both neighbouring clusters.
module lc_cluster
	import lc_pkg::*;
(
	// System clock and synchronous reset.
	input	logic		clk_sys,
	input	logic		rstn,
	// Avalon-MM register slave.
	input	logic [8:0]	avs_address,
	input	logic		avs_read,
	input	logic		avs_write,
	input	logic [31:0]	avs_writedata,
	input	logic [3:0]	avs_byteenable,
	output	logic [31:0]	avs_readdata,
	output	logic		avs_waitrequest,
	// Row clock lines and local control lines.
	input	logic [5:0]	row_clk,
	input	logic [8:0]	ctl_in,
	// Data routing into the cluster.
	input	logic [15:0]	lrt_in,
	input	logic [15:0]	dl_left_in,
	input	logic [15:0]	dl_right_in,
	input	logic		carry_in,
	input	logic		chain_in,
	// Data routing out of the cluster.
	output	logic [31:0]	elm_out,
	output	logic [15:0]	dl_out,
	output	logic		carry_out,
	output	logic		chain_out
);

	// Stored state.
	logic [31:0]	cfg_r [0:LC_WORDS-1];
	logic [31:0]	clk_cfg_r;
	logic [31:0]	use_r;
	logic		wait_r;
	logic [31:0]	rdata_r;
	logic [15:0]	q_r;
	logic [15:0]	q_nxt;
	logic [31:0]	out_r;
	logic [31:0]	out_nxt;
	logic [1:0]	src_prev_r;
	logic		cout_r;

	// Byte-lane merge for partial writes.
	function automatic logic [31:0] lc_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] msk);
		lc_merge = (old & ~msk) | (nw & msk);
	endfunction : lc_merge

	// Bus decode and read selection.
	logic		bus_req;
	logic		wr_go;
	logic		rd_take;
	logic		hit_arr;
	logic		hit_clk;
	logic		hit_use;
	logic		hit_stat;
	logic [5:0]	widx;
	logic [31:0]	bemask;
	logic [31:0]	rd_val;
	logic [31:0]	stat_word;
	assign bus_req = avs_read | avs_write;
	assign wr_go = avs_write & ~wait_r;
	assign rd_take = avs_read & wait_r;
	assign hit_arr = ~avs_address[8];
	assign widx = avs_address[7:2];
	assign hit_clk = avs_address[8:2] == LC_OFF_CLK[8:2];
	assign hit_use = avs_address[8:2] == LC_OFF_USE[8:2];
	assign hit_stat = avs_address[8:2] == LC_OFF_STAT[8:2];
	assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign rd_val = hit_arr ? cfg_r[widx] :
		hit_clk ? clk_cfg_r :
		hit_use ? use_r :
		hit_stat ? stat_word : 32'h0000_0000;

	// One wait cycle per access; read data is caught as waitrequest drops.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wait_r <= LC_RST_WAIT;
			rdata_r <= LC_RST_WORD;
		end else begin
			wait_r <= ~(bus_req & wait_r);
			if (rd_take)
				rdata_r <= rd_val;
		end
	end

	// Configuration writes land on the edge that completes the access.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			for (int i = 0; i < LC_WORDS; i++) begin
				cfg_r[i] <= LC_RST_WORD;
			end
			clk_cfg_r <= LC_RST_WORD;
			use_r <= LC_RST_WORD;
		end else if (wr_go) begin
			if (hit_arr)
				cfg_r[widx] <= lc_merge(cfg_r[widx], avs_writedata, bemask);
			else if (hit_clk)
				clk_cfg_r <= lc_merge(clk_cfg_r, avs_writedata, bemask);
			else if (hit_use)
				use_r <= lc_merge(use_r, avs_writedata, bemask);
		end
	end

	// Two clock sources only, each a row line or the local clock line.
	// Every cluster clock must pick one of them, so a third source cannot appear.
	logic [1:0]	src_lvl;
	logic [1:0]	src_rise;
	logic [1:0]	src_fall;
	logic [7:0]	lvl8;
	assign lvl8 = {ctl_in[LC_CI_CLK], ctl_in[LC_CI_CLK], row_clk};
	for (genvar gs = 0; gs < LC_NSRC; gs++) begin : g_src
		logic [2:0]	sel;
		assign sel = clk_cfg_r[LC_C_SRC0 + 3*gs +: 3];
		assign src_lvl[gs] = lvl8[sel];
	end
	assign src_rise = src_lvl & ~src_prev_r;
	assign src_fall = ~src_lvl & src_prev_r;

	// Cluster clocks as enable pulses, each gated by its own enable except clock zero under the asynchronous load.
	logic [2:0]	tick;
	logic [2:0]	ena_eff;
	logic [2:0]	gtick;
	logic [3:0]	gtick4;
	logic		aload_used;
	assign aload_used = use_r[LC_U_ALOAD];
	for (genvar gk = 0; gk < LC_NCLK; gk++) begin : g_clk
		logic	pick;
		logic	fall;
		assign pick = clk_cfg_r[LC_C_PICK + 2*gk];
		assign fall = clk_cfg_r[LC_C_PICK + 2*gk + 1];
		// Both edges of one source need two clocks with opposite fall bits.
		assign tick[gk] = fall ? src_fall[pick] : src_rise[pick];
		if (gk == 0) begin : g_e0
			// Using the asynchronous load drops enable zero, so clock zero runs ungated.
			assign ena_eff[gk] = aload_used | ~use_r[LC_U_ENA] | ctl_in[LC_CI_ENA];
		end else begin : g_en
			assign ena_eff[gk] = ~use_r[LC_U_ENA + gk] | ctl_in[LC_CI_ENA + gk];
		end
		assign gtick[gk] = tick[gk] & use_r[LC_U_CLK + gk] & ena_eff[gk];
	end
	assign gtick4 = {1'b0, gtick};

	// Asynchronous clears may come from row lines; enables, loads and the synchronous clear only from local lines.
	logic [1:0]	aclr_ln;
	logic [7:0]	row8;
	logic		sclr_ln;
	logic		aload_ln;
	logic		sload_ln;
	assign row8 = {2'b00, row_clk};
	for (genvar ga = 0; ga < 2; ga++) begin : g_aclr
		logic [2:0]	idx;
		logic		from_row;
		assign idx = use_r[LC_U_AIDX + 4*ga +: 3];
		assign from_row = use_r[LC_U_AROW + 4*ga];
		assign aclr_ln[ga] = use_r[LC_U_ACLR + ga] &
			(from_row ? row8[idx] : ctl_in[LC_CI_ACLR + ga]);
	end
	assign sclr_ln = use_r[LC_U_SCLR] & ctl_in[LC_CI_SCLR];
	assign aload_ln = use_r[LC_U_ALOAD] & ctl_in[LC_CI_ALOAD];
	assign sload_ln = use_r[LC_U_SLOAD] & ctl_in[LC_CI_SLOAD];

	// Status: control lines in use, enable conflict and every register value.
	logic [3:0]	act_cnt;
	logic		conflict;
	assign act_cnt = 4'($countones(use_r[LC_U_SLOAD:LC_U_CLK]));
	assign conflict = use_r[LC_U_ALOAD] & use_r[LC_U_ENA];
	assign stat_word = {q_r, 11'h000, conflict, act_cnt};

	// Shared routing pool seen by every element input.
	logic [63:0]	pool;
	logic [15:0]	loc_out;
	logic [8:0]	cy;
	logic [8:0]	sh;
	logic [7:0]	etick_v;
	logic [7:0]	aclr_v;
	logic [7:0]	aload_v;
	logic [7:0]	sclr_v;
	logic [7:0]	sload_v;
	logic [15:0]	comb_v;
	logic [15:0]	pk_v;
	assign pool = {lrt_in, dl_right_in, dl_left_in, loc_out};
	assign cy[0] = carry_in;
	assign sh[0] = 1'b0;

	// Eight elements in one loop; chains run from element zero upward.
	for (genvar ge = 0; ge < LC_ELEMS; ge++) begin : g_elm
		localparam int	B = LC_W_STRIDE * ge;
		logic [31:0]	m;
		logic [63:0]	t0;
		logic [63:0]	t1;
		logic [47:0]	sel;
		logic [7:0]	din;
		logic [1:0]	ch;
		lc_mode_e	mode;
		logic		a, b, c, d, e0, f0, e1, f1;
		logic		lo0, hi0, lo1, hi1, ad0, c0, s0, s1, x0, x1;
		assign m = cfg_r[B + LC_W_MODE];
		assign t0 = {cfg_r[B + LC_W_T0 + 1], cfg_r[B + LC_W_T0]};
		assign t1 = {cfg_r[B + LC_W_T1 + 1], cfg_r[B + LC_W_T1]};
		assign sel = {cfg_r[B + LC_W_SEL + 1][15:0], cfg_r[B + LC_W_SEL]};
		for (genvar gi = 0; gi < 8; gi++) begin : g_in
			assign din[gi] = pool[sel[6*gi +: 6]];
		end
		// Packing feedback replaces input a with this element's first register.
		assign a = m[LC_M_FB] ? q_r[2*ge] : din[0];
		assign {f1, e1, f0, e0, d, c, b} = din[7:1];
		assign mode = lc_mode_e'(m[LC_M_MODE +: 2]);

		// Pre-adder terms are four-input functions sharing inputs a and b.
		assign lo0 = t0[{2'b00, d, c, b, a}];
		assign hi0 = t0[{2'b01, f0, e0, b, a}];
		assign lo1 = t1[{2'b00, d, c, b, a}];
		assign hi1 = t1[{2'b01, f1, e1, b, a}];
		assign ad0 = (mode == LC_SHARED) ? sh[ge] : hi0;
		assign s0 = lo0 ^ ad0 ^ cy[ge];
		assign c0 = (lo0 & ad0) | (cy[ge] & (lo0 ^ ad0));
		assign s1 = lo1 ^ hi1 ^ c0;
		assign cy[ge+1] = (lo1 & hi1) | (c0 & (lo1 ^ hi1));
		assign sh[ge+1] = (mode == LC_SHARED) ? (lo1 & hi1) : 1'b0;

		// Seven-input form: f0 picks between two five-input halves.
		assign x0 = t0[{1'b0, e0, d, c, b, a}];
		assign x1 = t1[{1'b0, e1, d, c, b, a}];
		assign comb_v[2*ge] = (mode == LC_NORMAL) ? t0[{f0, e0, d, c, b, a}] :
			(mode == LC_EXTLUT) ? (f0 ? x1 : x0) : s0;
		assign comb_v[2*ge+1] = (mode == LC_NORMAL) ? t1[{f1, e1, d, c, b, a}] :
			(mode == LC_EXTLUT) ? 1'b0 : s1;

		// Load data shares the packing inputs e and f.
		assign pk_v[2*ge] = m[LC_M_PACKF] ? f0 : e0;
		assign pk_v[2*ge+1] = m[LC_M_PACKF] ? f1 : e1;
		if (ge == 0) begin : g_ch0
			assign ch[0] = chain_in;
		end else begin : g_chn
			assign ch[0] = q_r[2*ge-1];
		end
		assign ch[1] = q_r[2*ge];

		// Per-element control selection from the cluster-wide lines.
		assign etick_v[ge] = gtick4[m[LC_M_CLK +: 2]];
		assign aclr_v[ge] = aclr_ln[m[LC_M_ACLR]];
		assign aload_v[ge] = m[LC_M_ALOAD] & aload_ln;
		assign sclr_v[ge] = m[LC_M_SCLR] & sclr_ln;
		assign sload_v[ge] = m[LC_M_SLOAD] & sload_ln;

		for (genvar gr = 0; gr < 2; gr++) begin : g_reg
			localparam int	R = 2*ge + gr;
			localparam int	O = 4*ge + 2*gr;
			logic [1:0]	ds;
			logic		dv;
			assign ds = m[LC_M_D0 + 2*gr +: 2];
			assign dv = (ds == LC_D_COMB) ? comb_v[R] :
				(ds == LC_D_PACK) ? pk_v[R] : ch[gr];
			// Async terms ignore the gated clock; sync terms need its pulse.
			assign q_nxt[R] = aclr_v[ge] ? 1'b0 :
				aload_v[ge] ? pk_v[R] :
				~etick_v[ge] ? q_r[R] :
				sclr_v[ge] ? 1'b0 :
				sload_v[ge] ? pk_v[R] : dv;
			// Each output picks the bypassed result or the register.
			assign out_nxt[O] = m[LC_M_OSEL + 2*gr] ? q_nxt[R] : comb_v[R];
			assign out_nxt[O+1] = m[LC_M_OSEL + 2*gr + 1] ? q_nxt[R] : comb_v[R];
			assign loc_out[R] = out_r[O];
		end
	end

	// Element registers and output stage.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			q_r <= 16'h0000;
			out_r <= 32'h0000_0000;
			src_prev_r <= 2'h0;
			cout_r <= 1'b0;
		end else begin
			q_r <= q_nxt;
			out_r <= out_nxt;
			src_prev_r <= src_lvl;
			cout_r <= cy[LC_ELEMS];
		end
	end

	// Outputs straight from flops.
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign elm_out = out_r;
	assign dl_out = loc_out;
	assign carry_out = cout_r;
	assign chain_out = q_r[15];

	// Checks on the cluster behaviour.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	sequence bus_req_s;
		bus_req && avs_waitrequest;
	endsequence
	sequence no_async0_s;
		!aclr_v[0] && !aload_v[0];
	endsequence

	bus_ack_a: assert property (bus_req_s |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus access not acknowledged after one wait cycle");
	cnt_cap_a: assert property (act_cnt <= LC_MAX_CTL)
		else $error("more than eleven control lines active");
	two_src_a: assert property ((src_rise == 2'h0 && src_fall == 2'h0) |-> gtick == 3'h0)
		else $error("cluster clock without a source edge");
	edge_pair_a: assert property (
		(clk_cfg_r[LC_C_PICK] == clk_cfg_r[LC_C_PICK+2] &&
		clk_cfg_r[LC_C_PICK+1] != clk_cfg_r[LC_C_PICK+3]) |-> !(tick[0] && tick[1]))
		else $error("both edges of one source in one cycle");
	gate_stop_a: assert property (!ena_eff[1] |-> !gtick[1] && !etick_v[0] ||
		cfg_r[LC_W_MODE][LC_M_CLK +: 2] != 2'h1)
		else $error("disabled clock still ticking");
	ena0_gone_a: assert property (aload_used && $rose(src_lvl[0]) && use_r[LC_U_CLK] &&
		!clk_cfg_r[LC_C_PICK] && !clk_cfg_r[LC_C_PICK+1] |-> gtick[0])
		else $error("enable zero still gating under async load");
	aclr_now_a: assert property (aclr_v[0] |=> q_r[1:0] == 2'h0 ##1 elm_out[1] == q_r[0] ||
		!cfg_r[LC_W_MODE][LC_M_OSEL+1])
		else $error("async clear did not act at once");
	preset_a: assert property (!aclr_v[0] && aload_v[0] && pk_v[0] |=> q_r[0])
		else $error("async load with data one did not preset");
	sync_hold_a: assert property (no_async0_s and !etick_v[0] |=> $stable(q_r[1:0]))
		else $error("register moved without a gated edge");
	chain_shift_a: assert property (
		etick_v[1] && !aclr_v[1] && !aload_v[1] && !sclr_v[1] && !sload_v[1] &&
		cfg_r[LC_W_STRIDE+LC_W_MODE][LC_M_D0 +: 2] == 2'h2 |=> q_r[2] == $past(q_r[1]))
		else $error("register chain did not shift");
	bypass_a: assert property (!cfg_r[LC_W_MODE][LC_M_OSEL] |=> elm_out[0] == $past(comb_v[0]))
		else $error("bypass output not the look-up result");
	both_view_a: assert property (cfg_r[LC_W_MODE][LC_M_OSEL+1] |=> elm_out[1] == q_r[0])
		else $error("registered output differs from register");
	// The enable is checked against the pins, so a wrong enable select also shows up here.
	sequence ena0_low_s;
		!aload_used && use_r[LC_U_ENA] && !ctl_in[LC_CI_ENA];
	endsequence
	ena_off_a: assert property (ena0_low_s |-> !gtick[0])
		else $error("clock zero ticked with its enable low");
	pack_load_a: assert property (!aclr_v[0] && aload_v[0] |=>
		q_r[0] == $past(pk_v[0]))
		else $error("async load did not take the packing input");
	chain_in_a: assert property (
		etick_v[0] && !aclr_v[0] && !aload_v[0] && !sclr_v[0] && !sload_v[0] &&
		cfg_r[LC_W_MODE][LC_M_D0 +: 2] == 2'h2 |=> q_r[0] == $past(chain_in))
		else $error("register chain did not take the chain input");

endmodule : lc_cluster

/* File: lc_fabric.sv */
`timescale 1ns/100ps
module lc_fabric (
	// Clock and the links the cluster drives out.
	input	logic		clk_sys,
	input	logic [15:0]	dl_out,
	// Lines the fabric drives into the cluster.
	output	logic [5:0]	row_clk,
	output	logic [15:0]	lrt_in,
	output	logic [15:0]	dl_left_in,
	output	logic [15:0]	dl_right_in,
	output	logic		carry_in,
	output	logic		chain_in
);
	// Row clocks idle low until a test moves one.
	initial begin
		row_clk = 6'h00;
		lrt_in = 16'h0000;
		dl_left_in = 16'h0000;
		dl_right_in = 16'hffff;
		carry_in = 1'b0;
		chain_in = 1'b0;
	end

	// The left neighbour never holds still; the right neighbour is dl_out inverted and registered, so it moves one edge after dl_out does.
	always @(posedge clk_sys) begin
		dl_left_in <= {dl_left_in[14:0], ~dl_left_in[15]};
		dl_right_in <= ~dl_out;
	end

	// Lines move only just after a system edge, as the tree is synchronous.
	task automatic set_row(input int idx, input logic v);
		@(posedge clk_sys);
		row_clk[idx] <= v;
	endtask : set_row

	task automatic set_lrt(input logic [15:0] v);
		@(posedge clk_sys);
		lrt_in <= v;
	endtask : set_lrt

	task automatic set_chain(input logic v);
		@(posedge clk_sys);
		chain_in <= v;
	endtask : set_chain
endmodule : lc_fabric

/* File: lc_cluster_test.sv */
`timescale 1ns/100ps
module lc_cluster_test
	import lc_pkg::*;
;
	// Bus side.
	logic		clk_sys;
	logic		rstn;
	logic [8:0]	avs_address;
	logic		avs_read;
	logic		avs_write;
	logic [31:0]	avs_writedata;
	logic [3:0]	avs_byteenable;
	logic [31:0]	avs_readdata;
	logic		avs_waitrequest;
	// Fabric side.
	logic [5:0]	row_clk;
	logic [8:0]	ctl_in;
	logic [15:0]	lrt_in, dl_left_in, dl_right_in, dl_out;
	logic		carry_in, chain_in, carry_out, chain_out;
	logic [31:0]	elm_out;
	logic [31:0]	rd_q;
	int		failures;
	int		cmp_count;

	typedef struct {
		logic		wr;
		logic [8:0]	addr;
		logic [31:0]	data;
		logic [3:0]	be;
		logic [31:0]	exp;
	} lc_row_s;

	// Write then read back; status counts used controls and flags the enable clash.
	lc_row_s rows [11] = '{
		'{1'b0, LC_OFF_CLK, 32'h0, 4'hf, 32'h0},
		'{1'b1, LC_OFF_CLK, 32'h0000_0fff, 4'hf, 32'h0000_0fff},
		'{1'b1, LC_OFF_USE, 32'h0007_ffff, 4'hf, 32'h0007_ffff},
		'{1'b1, LC_OFF_USE, 32'h0000_07ff, 4'hf, 32'h0000_07ff},
		'{1'b0, LC_OFF_STAT, 32'h0, 4'hf, 32'h0000_001b},
		'{1'b1, LC_OFF_STAT, 32'hffff_ffff, 4'hf, 32'h0000_001b},
		'{1'b1, 9'h10c, 32'h1234_5678, 4'hf, 32'h0},
		'{1'b1, 9'h000, 32'hffff_ffff, 4'hf, 32'hffff_ffff},
		'{1'b1, 9'h000, 32'h0, 4'h2, 32'hffff_00ff},
		'{1'b1, LC_OFF_USE, 32'h0000_0009, 4'hf, 32'h0000_0009},
		'{1'b0, LC_OFF_STAT, 32'h0, 4'hf, 32'h0000_0002}
	};

	lc_cluster i_lc_cluster (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .row_clk(row_clk), .ctl_in(ctl_in),
		.lrt_in(lrt_in), .dl_left_in(dl_left_in), .dl_right_in(dl_right_in),
		.carry_in(carry_in), .chain_in(chain_in), .elm_out(elm_out), .dl_out(dl_out),
		.carry_out(carry_out), .chain_out(chain_out));

	lc_fabric i_lc_fabric (.clk_sys(clk_sys), .dl_out(dl_out), .row_clk(row_clk),
		.lrt_in(lrt_in), .dl_left_in(dl_left_in), .dl_right_in(dl_right_in),
		.carry_in(carry_in), .chain_in(chain_in));

	// System clock at 50 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_out(input int idx, input logic exp);
		chk({31'h0, elm_out[idx]}, {31'h0, exp});
	endtask : chk_out

	// One access, held until waitrequest is sampled low; an idle edge follows.
	task automatic xfer(input logic rd, input logic [8:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= rd;
		avs_write <= ~rd;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		chk({31'h0, avs_waitrequest}, 32'h0);
		rd_q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : xfer

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		xfer(1'b0, a, d, 4'hf);
	endtask : wr

	// Row line 2 feeds clock source 0; allow the edge to be sampled and land.
	task automatic row_step(input logic v);
		i_lc_fabric.set_row(2, v);
		repeat (4) @(posedge clk_sys);
	endtask : row_step

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	// A hang counts as a mismatch and ends the run the ordinary way.
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		wrap_up();
	end

	// Main sequence: reset, table rows, then the control-line cases by hand.
	initial begin
		rstn = 1'b0;
		avs_address = 9'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		ctl_in = 9'h000;
		failures = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk_sys);
		chk({31'h0, avs_waitrequest}, {31'h0, LC_RST_WAIT});
		chk(avs_readdata, LC_RST_WORD);
		chk(elm_out, 32'h0000_0000);
		chk({16'h0000, dl_out}, 32'h0000_0000);
		chk({30'h0, carry_out, chain_out}, 32'h0000_0000);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		foreach (rows[i]) begin
			if (rows[i].wr)
				xfer(1'b0, rows[i].addr, rows[i].data, rows[i].be);
			xfer(1'b1, rows[i].addr, 32'h0, 4'hf);
			chk(rd_q, rows[i].exp);
		end
		wr(9'h000, 32'hffff_ffff);
		wr(9'h004, 32'hffff_ffff);
		wr(9'h018, 32'h0000_8000);
		wr(9'h020, 32'hffff_ffff);
		wr(9'h024, 32'hffff_ffff);
		wr(9'h038, 32'h0000_8001);
		wr(LC_OFF_CLK, 32'h0000_0202);
		wr(LC_OFF_USE, 32'h0000_000b);
		ctl_in <= 9'h002;
		repeat (4) @(posedge clk_sys);
		chk_out(0, 1'b1);
		chk_out(1, 1'b0);
		chk({31'h0, dl_out[0]}, 32'h1);
		row_step(1'b1);
		chk_out(1, 1'b1);
		chk_out(5, 1'b0);
		row_step(1'b0);
		chk_out(5, 1'b1);
		wr(9'h000, 32'h0);
		wr(9'h004, 32'h0);
		ctl_in <= 9'h000;
		row_step(1'b1);
		chk_out(1, 1'b1);
		ctl_in <= 9'h002;
		row_step(1'b0);
		row_step(1'b1);
		chk_out(1, 1'b0);
		wr(9'h000, 32'hffff_ffff);
		wr(9'h004, 32'hffff_ffff);
		wr(9'h018, 32'h0000_8008);
		wr(LC_OFF_USE, 32'h0000_014b);
		row_step(1'b0);
		row_step(1'b1);
		chk_out(1, 1'b1);
		ctl_in <= 9'h042;
		repeat (5) @(posedge clk_sys);
		chk_out(1, 1'b1);
		row_step(1'b0);
		row_step(1'b1);
		chk_out(1, 1'b0);
		ctl_in <= 9'h002;
		i_lc_fabric.set_lrt(16'h8000);
		wr(9'h010, 32'h3f00_0000);
		wr(9'h018, 32'h0000_8028);
		wr(LC_OFF_USE, 32'h0000_024b);
		ctl_in <= 9'h082;
		repeat (3) @(posedge clk_sys);
		chk_out(1, 1'b1);
		ctl_in <= 9'h012;
		repeat (3) @(posedge clk_sys);
		chk_out(1, 1'b0);
		ctl_in <= 9'h000;
		row_step(1'b0);
		row_step(1'b1);
		chk_out(1, 1'b1);
		wr(9'h018, 32'h0000_8400);
		wr(LC_OFF_USE, 32'h0000_000b);
		ctl_in <= 9'h002;
		i_lc_fabric.set_chain(1'b0);
		row_step(1'b0);
		row_step(1'b1);
		chk_out(1, 1'b0);
		xfer(1'b1, LC_OFF_STAT, 32'h0, 4'hf);
		chk(rd_q, 32'h0004_0003);
		// Element 1 register 0 now shifts in element 0 register 1, which is low.
		wr(9'h038, 32'h0000_8401);
		row_step(1'b0);
		chk_out(5, 1'b0);
		// Element 2 copies input a; feedback swaps it for its own cleared register.
		wr(9'h040, 32'haaaa_aaaa);
		wr(9'h044, 32'haaaa_aaaa);
		wr(9'h058, 32'h0000_0003);
		repeat (2) @(posedge clk_sys);
		chk_out(8, 1'b1);
		wr(9'h058, 32'h0000_2003);
		repeat (2) @(posedge clk_sys);
		chk_out(8, 1'b0);
		// All-ones tables: the adders give sum 0 then 1; extended mode blanks half 1.
		wr(9'h040, 32'hffff_ffff);
		wr(9'h044, 32'hffff_ffff);
		wr(9'h048, 32'hffff_ffff);
		wr(9'h04c, 32'hffff_ffff);
		wr(9'h058, 32'h0000_0183);
		repeat (2) @(posedge clk_sys);
		chk_out(8, 1'b0);
		chk_out(10, 1'b1);
		wr(9'h058, 32'h0000_0083);
		repeat (2) @(posedge clk_sys);
		chk_out(8, 1'b1);
		chk_out(10, 1'b0);
		wrap_up();
	end
endmodule : lc_cluster_test
